/* File: design/alarm_io_pkg.sv */
/*
 * Shared constants for the alarm, status and control I/O block:
 * register offsets, field positions, reset values and unit scaling.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package alarm_io_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] LIMIT1_OFS = 8'h04;
	localparam logic [7:0] LIMIT2_OFS = 8'h08;
	localparam logic [7:0] STATE_OFS = 8'h0c;
	localparam logic [7:0] EVENT_OFS = 8'h10;
	localparam logic [7:0] MASK_OFS = 8'h14;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_EN1_BIT = 0;
	localparam int CTRL_EN2_BIT = 1;
	localparam int CTRL_UNITS_BIT = 2;
	localparam int CTRL_CAL_LSB = 4;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0037;

	// ----------------------------------------------------------------
	// Status pin positions (conducting = 1)
	// ----------------------------------------------------------------
	localparam int ST_SYS_OK = 0;
	localparam int ST_VALID = 1;
	localparam int ST_HIGH = 2;
	localparam int ST_ZERO = 3;
	localparam int ST_SPAN = 4;
	localparam int ST_DIAG = 5;
	localparam int ST_LOW = 6;
	localparam int ST_UNUSED = 7;

	// ----------------------------------------------------------------
	// Event bits (event, mask registers share this layout)
	// ----------------------------------------------------------------
	localparam int EV_ALARM1 = 0;
	localparam int EV_ALARM2 = 1;
	localparam int EV_REMOTE = 2;
	localparam int EV_FAULT = 3;
	localparam int EV_W = 4;

	// ----------------------------------------------------------------
	// Limits, LSB = 0.1 unit; reset values are in ppm
	// ----------------------------------------------------------------
	localparam int LIMIT_W = 16;
	localparam logic [15:0] LIMIT1_RST = 16'h03e8; // 100.0 ppm
	localparam logic [15:0] LIMIT2_RST = 16'h0bb8; // 300.0 ppm
	// Q16 factors: ppm -> mg/m3 is x1.3387, mg/m3 -> ppm is x(1/1.3387)
	// Gives 133.9 and 401.6 for the two default limits, and exact round trips
	localparam logic [16:0] PPM_TO_MG_Q16 = 17'h156b5;
	localparam logic [16:0] MG_TO_PPM_Q16 = 17'h0bf3b;
	localparam logic [33:0] ROUND_Q16 = 34'h0_0000_8000;

	// Calibration modes
	typedef enum logic [1:0] {
		CAL_NONE,
		CAL_ZERO,
		CAL_SPAN,
		CAL_MID
	} cal_mode_e;

endpackage

/* File: design/alarm_status_control_io.sv */
/*
 * Concentration alarms, eight-position status port and six-input
 * remote calibration port, with a classic Wishbone register slave.
 * Assumes conc_i and the instrument state inputs come from logic on
 * mclk_i; control pins come from outside and are synchronised here.
 */
// Behaviour
// RULE1 - Each enabled alarm closes its output while concentration exceeds its limit.
// RULE2 - After reset alarm one is disabled, limit 100 ppm, drives first output.
// RULE3 - After reset alarm two is disabled, limit 300 ppm, drives second output.
// RULE4 - A units change rescales both limits so they keep their meaning.
// RULE5 - Alarm outputs stay inactive while any calibration mode is active.
// RULE6 - Health output conducts only while no fault is present.
// RULE7 - Valid output conducts while the measurement is valid, else off.
// RULE8 - In auto range, high or low range output follows the selected range.
// RULE9 - Zero calibration output conducts exactly while in zero calibration.
// RULE10 - Span calibration output conducts exactly while in span calibration; the code also drives it during mid-point calibration.
// RULE11 - Diagnostic output conducts exactly while in diagnostic mode.
// RULE12 - First control input enters zero calibration, flagged as remote.
// RULE13 - Second control input enters span calibration, flagged as remote.
// RULE14 - Third control input enters mid-point calibration, flagged as remote.
// RULE15 - Eighth status output never conducts; three spare control inputs ignored.
// RULE16 - Control inputs synchronised; zero beats span, span beats mid-point.
`timescale 1ns/1ns

module alarm_status_control_io
	import alarm_io_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Instrument state, same clock
	input wire logic [LIMIT_W-1:0] conc_i,
	input wire logic fault_i,
	input wire logic measurement_valid_flag_i,
	input wire logic auto_range_i,
	input wire logic high_range_i,
	input wire logic diagnostic_flag_i,
	// Control pins A..F, asynchronous
	input wire logic [5:0] ctrl_pin_i,
	// Outputs
	output logic first_alarm_output_o,
	output logic second_alarm_output_o,
	output logic [7:0] status_port_o,
	output logic [1:0] cal_mode_o,
	output logic remote_cal_o,
	output logic remote_midpoint_indication_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Rescale a limit by a Q16 factor with rounding and saturation
	function automatic logic [LIMIT_W-1:0] rescale(input logic [LIMIT_W-1:0] v, input logic to_mg);
		logic [33:0] prod;
		prod = {18'h0, v} * {17'h0, (to_mg ? PPM_TO_MG_Q16 : MG_TO_PPM_Q16)} + ROUND_Q16;
		if (|prod[33:32]) begin
			rescale = 16'hffff;
		end else begin
			rescale = prod[31:16];
		end
	endfunction

	// Merge write data into a register under byte enables and a field mask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel, input logic [31:0] fmask);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & fmask;
		merge = (old & ~m) | (wd & m);
	endfunction

	// ----------------------------------------------------------------
	// Control pin synchroniser
	// ----------------------------------------------------------------
	// Only A..C are used; D..F never enter the clock domain
	logic [2:0] pin_meta_reg;
	logic [2:0] pin_sync_reg;
	logic [2:0] pin_meta_next;
	logic [2:0] pin_sync_next;

	// Two stages before anything looks at the pins
	always_comb begin
		pin_meta_next = ctrl_pin_i[2:0]; // RULE16 RULE15
		pin_sync_next = pin_meta_reg;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
		end else begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
		end
	end

	// ----------------------------------------------------------------
	// Register file and bus slave
	// ----------------------------------------------------------------
	logic en1_reg, en1_next;
	logic en2_reg, en2_next;
	logic units_reg, units_next;
	cal_mode_e sw_cal_reg, sw_cal_next;
	logic [LIMIT_W-1:0] limit1_reg, limit1_next;
	logic [LIMIT_W-1:0] limit2_reg, limit2_next;
	logic [EV_W-1:0] event_reg, event_next;
	logic [EV_W-1:0] mask_reg, mask_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;

	cal_mode_e mode_reg, mode_next;
	logic remote_reg, remote_next;
	logic alarm1_reg, alarm1_next;
	logic alarm2_reg, alarm2_next;
	logic [7:0] status_reg, status_next;
	logic mid_ind_reg, mid_ind_next;
	logic fault_d_reg, fault_d_next;

	logic wr_commit;
	logic [31:0] ctrl_word;
	logic [31:0] ctrl_new;
	logic [31:0] lim_new;
	logic [31:0] mask_new;
	logic [EV_W-1:0] ev_set;

	// Write lands on the edge where the master samples ack
	assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign ctrl_word = {26'h0, sw_cal_reg, 1'b0, units_reg, en2_reg, en1_reg};

	// Bus answer: ack one cycle after the request, dropped the next cycle
	always_comb begin
		ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
		rdata_next = rdata_reg;
		if (wb_cyc_i && wb_stb_i && !ack_reg) begin
			unique case (wb_adr_i)
				CTRL_OFS: rdata_next = ctrl_word;
				LIMIT1_OFS: rdata_next = {16'h0, limit1_reg};
				LIMIT2_OFS: rdata_next = {16'h0, limit2_reg};
				STATE_OFS: rdata_next = {16'h0, status_reg, 1'b0, mid_ind_reg, remote_reg, mode_reg,
					1'b0, alarm2_reg, alarm1_reg};
				EVENT_OFS: rdata_next = {28'h0, event_reg};
				MASK_OFS: rdata_next = {28'h0, mask_reg};
				default: rdata_next = 32'h0; // Unmapped reads as zero
			endcase
		end
	end

	// Control, limits and mask; a units flip rescales both limits
	always_comb begin
		ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i, CTRL_WMASK);
		lim_new = merge({16'h0, (wb_adr_i == LIMIT1_OFS) ? limit1_reg : limit2_reg}, wb_dat_i, wb_sel_i,
			32'h0000_ffff);
		mask_new = merge({28'h0, mask_reg}, wb_dat_i, wb_sel_i, 32'h0000_000f);
		en1_next = en1_reg;
		en2_next = en2_reg;
		units_next = units_reg;
		sw_cal_next = sw_cal_reg;
		limit1_next = limit1_reg;
		limit2_next = limit2_reg;
		mask_next = mask_reg;
		if (wr_commit) begin
			unique case (wb_adr_i)
				CTRL_OFS: begin
					en1_next = ctrl_new[CTRL_EN1_BIT];
					en2_next = ctrl_new[CTRL_EN2_BIT];
					units_next = ctrl_new[CTRL_UNITS_BIT];
					sw_cal_next = cal_mode_e'(ctrl_new[CTRL_CAL_LSB +: 2]);
					if (ctrl_new[CTRL_UNITS_BIT] != units_reg) begin
						limit1_next = rescale(limit1_reg, ctrl_new[CTRL_UNITS_BIT]); // RULE4
						limit2_next = rescale(limit2_reg, ctrl_new[CTRL_UNITS_BIT]); // RULE4
					end
				end
				LIMIT1_OFS: limit1_next = lim_new[LIMIT_W-1:0];
				LIMIT2_OFS: limit2_next = lim_new[LIMIT_W-1:0];
				MASK_OFS: mask_next = mask_new[EV_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events: a new event wins over a write-one clear
	always_comb begin
		ev_set = '0;
		ev_set[EV_ALARM1] = alarm1_next & ~alarm1_reg;
		ev_set[EV_ALARM2] = alarm2_next & ~alarm2_reg;
		ev_set[EV_REMOTE] = remote_next & ~remote_reg;
		ev_set[EV_FAULT] = fault_i & ~fault_d_reg;
		event_next = event_reg;
		if (wr_commit && wb_adr_i == EVENT_OFS && wb_sel_i[0]) begin
			event_next = event_reg & ~wb_dat_i[EV_W-1:0];
		end
		event_next = event_next | ev_set;
		irq_next = |(event_next & mask_next);
		fault_d_next = fault_i;
	end

	// ----------------------------------------------------------------
	// Calibration mode selection
	// ----------------------------------------------------------------
	// Remote pins override software; a remote mode lasts while its pin is held
	always_comb begin
		remote_next = 1'b1;
		if (pin_sync_reg[0]) begin
			mode_next = CAL_ZERO; // RULE12 RULE16
		end else if (pin_sync_reg[1]) begin
			mode_next = CAL_SPAN; // RULE13 RULE16
		end else if (pin_sync_reg[2]) begin
			mode_next = CAL_MID; // RULE14
		end else begin
			mode_next = sw_cal_next;
			remote_next = 1'b0;
		end
		mid_ind_next = remote_next & (mode_next == CAL_MID); // RULE14
	end

	// ----------------------------------------------------------------
	// Alarms and status port
	// ----------------------------------------------------------------
	// Calibration suppresses alarms so span gas cannot trip them
	always_comb begin
		alarm1_next = en1_reg & (conc_i > limit1_reg) & (mode_next == CAL_NONE); // RULE1 RULE2 RULE5
		alarm2_next = en2_reg & (conc_i > limit2_reg) & (mode_next == CAL_NONE); // RULE1 RULE3 RULE5
		status_next = 8'h00;
		status_next[ST_SYS_OK] = ~fault_i; // RULE6
		status_next[ST_VALID] = measurement_valid_flag_i; // RULE7
		status_next[ST_HIGH] = auto_range_i & high_range_i; // RULE8
		status_next[ST_LOW] = auto_range_i & ~high_range_i; // RULE8
		status_next[ST_ZERO] = (mode_next == CAL_ZERO); // RULE9
		status_next[ST_SPAN] = (mode_next == CAL_SPAN) | (mode_next == CAL_MID); // RULE10
		status_next[ST_DIAG] = diagnostic_flag_i; // RULE11
		status_next[ST_UNUSED] = 1'b0; // RULE15
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			en1_reg <= 1'b0; // RULE2
			en2_reg <= 1'b0; // RULE3
			units_reg <= 1'b0;
			sw_cal_reg <= CAL_NONE;
			limit1_reg <= LIMIT1_RST; // RULE2
			limit2_reg <= LIMIT2_RST; // RULE3
			event_reg <= '0;
			mask_reg <= '0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
			irq_reg <= 1'b0;
			mode_reg <= CAL_NONE;
			remote_reg <= 1'b0;
			alarm1_reg <= 1'b0;
			alarm2_reg <= 1'b0;
			status_reg <= 8'h00;
			mid_ind_reg <= 1'b0;
			fault_d_reg <= 1'b0;
		end else begin
			en1_reg <= en1_next;
			en2_reg <= en2_next;
			units_reg <= units_next;
			sw_cal_reg <= sw_cal_next;
			limit1_reg <= limit1_next;
			limit2_reg <= limit2_next;
			event_reg <= event_next;
			mask_reg <= mask_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			mode_reg <= mode_next;
			remote_reg <= remote_next;
			alarm1_reg <= alarm1_next;
			alarm2_reg <= alarm2_next;
			status_reg <= status_next;
			mid_ind_reg <= mid_ind_next;
			fault_d_reg <= fault_d_next;
		end
	end

	// Every output straight from a flip-flop
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign first_alarm_output_o = alarm1_reg;
	assign second_alarm_output_o = alarm2_reg;
	assign status_port_o = status_reg;
	assign cal_mode_o = mode_reg;
	assign remote_cal_o = remote_reg;
	assign remote_midpoint_indication_o = mid_ind_reg;
	assign irq_o = irq_reg;

endmodule

/* File: test/alarm_io_chk.sv */
/* Port checker for the alarm, status and control I/O block.
   Assumes one clock and a synchronous active-low reset; bound to the top module. */
`timescale 1ns/1ns
module alarm_io_chk
	import alarm_io_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic fault_i,
	input wire logic measurement_valid_flag_i,
	input wire logic auto_range_i,
	input wire logic high_range_i,
	input wire logic diagnostic_flag_i,
	input wire logic [5:0] ctrl_pin_i,
	input wire logic first_alarm_output_o,
	input wire logic second_alarm_output_o,
	input wire logic [7:0] status_port_o,
	input wire logic [1:0] cal_mode_o,
	input wire logic remote_cal_o,
	input wire logic remote_midpoint_indication_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------------------
	// Status outputs, one edge behind their causes
	// ------------------------------------------------------------
	// Guarded by the past reset since status is cleared while in reset
	a_health_ok: assert property ($past(rst_n_i) |-> status_port_o[ST_SYS_OK] == !$past(fault_i))
		else $error("health output wrong");
	a_valid_out: assert property ($past(rst_n_i) |->
		status_port_o[ST_VALID] == $past(measurement_valid_flag_i)) else $error("valid output wrong");
	a_range_out: assert property ($past(rst_n_i) |->
		status_port_o[ST_HIGH] == ($past(auto_range_i) && $past(high_range_i))
		&& status_port_o[ST_LOW] == ($past(auto_range_i) && !$past(high_range_i)))
		else $error("range outputs wrong");
	a_diag_out: assert property ($past(rst_n_i) |-> status_port_o[ST_DIAG] == $past(diagnostic_flag_i))
		else $error("diagnostic output wrong");
	a_zero_stat: assert property ($past(rst_n_i) |-> status_port_o[ST_ZERO] == (cal_mode_o == CAL_ZERO))
		else $error("zero status wrong");
	a_span_stat: assert property ($past(rst_n_i) |-> status_port_o[ST_SPAN] == cal_mode_o[1])
		else $error("span status wrong");
	a_spare_off: assert property (!status_port_o[ST_UNUSED])
		else $error("spare status conducts");
	// ------------------------------------------------------------
	// Calibration modes and remote pins
	// ------------------------------------------------------------
	a_cal_quiet: assert property (cal_mode_o != 2'h0 && $past(cal_mode_o) != 2'h0 |->
		!first_alarm_output_o && !second_alarm_output_o) else $error("alarm during calibration");
	a_pin_zero: assert property (ctrl_pin_i[0] [*4] |=> cal_mode_o == CAL_ZERO && remote_cal_o)
		else $error("zero pin ignored");
	a_pin_span: assert property ((ctrl_pin_i[1:0] == 2'h2) [*4] |=>
		cal_mode_o == CAL_SPAN && remote_cal_o) else $error("span pin ignored");
	a_pin_mid: assert property ((ctrl_pin_i[2:0] == 3'h4) [*4] |=>
		cal_mode_o == CAL_MID && remote_midpoint_indication_o) else $error("mid pin ignored");
endmodule
bind alarm_status_control_io alarm_io_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fault_i(fault_i),
	.measurement_valid_flag_i(measurement_valid_flag_i), .auto_range_i(auto_range_i), .high_range_i(high_range_i),
	.diagnostic_flag_i(diagnostic_flag_i), .ctrl_pin_i(ctrl_pin_i), .first_alarm_output_o(first_alarm_output_o),
	.second_alarm_output_o(second_alarm_output_o), .status_port_o(status_port_o), .cal_mode_o(cal_mode_o),
	.remote_cal_o(remote_cal_o), .remote_midpoint_indication_o(remote_midpoint_indication_o));

/* File: test/plc_model.sv */
/* External controller model driving the six control pins.
   Assumes commands come from the bench as levels on the same clock. */
`timescale 1ns/1ns
module plc_model (
	input wire logic mclk_i,
	input wire logic [5:0] cmd_i,
	output logic [5:0] ctrl_pin_o = 6'h0
);
	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Levels change just after an edge and stay held, like a relay output
	always @(posedge mclk_i) begin
		ctrl_pin_o <= cmd_i;
	end
endmodule

/* File: test/test_alarm_status_control_io.sv */
/* Self-checking bench for the alarm, status and control I/O block.
   Assumes the checker is bound and a controller model drives the pins. */
`timescale 1ns/1ns
module test_alarm_status_control_io
	import alarm_io_pkg::*;
;
	logic mclk_i;
	logic rst_n_i = 1'h0;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rdat;
	logic ack, al1, al2, rcal, rmid, irq;
	logic [15:0] conc = 16'h0;
	logic fault = 1'h0;
	logic valid = 1'h0;
	logic auto_rng = 1'h0;
	logic high_rng = 1'h0;
	logic diag = 1'h0;
	logic [5:0] cmd = 6'h0;
	logic [5:0] pins;
	logic [7:0] status;
	logic [1:0] mode;
	int error_cnt = 0;
	int checked = 0;

	alarm_status_control_io u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .conc_i(conc),
		.fault_i(fault), .measurement_valid_flag_i(valid), .auto_range_i(auto_rng), .high_range_i(high_rng),
		.diagnostic_flag_i(diag), .ctrl_pin_i(pins), .first_alarm_output_o(al1), .second_alarm_output_o(al2),
		.status_port_o(status), .cal_mode_o(mode), .remote_cal_o(rcal), .remote_midpoint_indication_o(rmid),
		.irq_o(irq));
	plc_model u_plc (.mclk_i(mclk_i), .cmd_i(cmd), .ctrl_pin_o(pins));

	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Q16 rescale with rounding; saturation mirrors the limit width
	function automatic logic [31:0] scale(input logic [15:0] v, input logic [16:0] f);
		logic [33:0] p;
		p = 34'(v) * 34'(f) + ROUND_Q16;
		return (p[33:16] > 18'h0ffff) ? 32'h0000_ffff : {16'h0, p[31:16]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Classic single cycle; held until ack is sampled, then released for a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk_i);
		{cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack !== 1'h1 && n < 20);
		q = dat_o;
		{cyc, stb} <= 2'h0;
		if (n >= 20) begin
			error_cnt++;
			$display("[ERR] %0t bus timeout", $time);
			complete_run();
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hef4d6fa8));
		tick(5);
		rst_n_i <= 1'h1;
		wb(1'h0, LIMIT1_OFS, 32'h0, rdat); chk(rdat, 32'h0000_03e8);
		wb(1'h0, LIMIT2_OFS, 32'h0, rdat); chk(rdat, 32'h0000_0bb8);
		conc <= 16'hffff;
		tick(3); chk({al1, al2}, 32'h0);
		$display("test reset done");
		wb(1'h1, CTRL_OFS, 32'h3, rdat);
		for (int i = 0; i < 12; i++) begin
			conc <= (i == 0) ? 16'h03e8 : (i == 1) ? 16'h03e9 : (i == 2) ? 16'h0bb9 : 16'($urandom_range(0, 4000));
			tick(3);
			chk({al1, al2}, {conc > 16'h03e8, conc > 16'h0bb8});
		end
		$display("test alarms done");
		for (int i = 0; i < 10; i++) begin
			{fault, valid, auto_rng, high_rng, diag} <= 5'($urandom);
			tick(2);
			chk(status[2:0], {auto_rng & high_rng, valid, ~fault});
			chk(status[7:3], {1'h0, auto_rng & ~high_rng, diag, 2'h0});
		end
		$display("test status done");
		{fault, conc} <= 17'h0;
		tick(3);
		wb(1'h1, EVENT_OFS, 32'hf, rdat);
		wb(1'h1, MASK_OFS, 32'h1, rdat);
		conc <= 16'h07d0;
		tick(3); chk(irq, 32'h1);
		wb(1'h1, MASK_OFS, 32'h0, rdat); tick(2); chk(irq, 32'h0);
		wb(1'h1, MASK_OFS, 32'h1, rdat); tick(2); chk(irq, 32'h1);
		wb(1'h1, EVENT_OFS, 32'h1, rdat); tick(2); chk(irq, 32'h0);
		$display("test interrupt done");
		// Higher pins held with lower ones checks priority; spare pins toggle at random
		for (int i = 0; i < 3; i++) begin
			cmd <= {3'($urandom), 3'h7 << i};
			tick(6);
			chk({mode, rcal, rmid}, {2'(i + 1), 1'h1, i == 2});
			chk({status[4:3], al1}, {i != 0, i == 0, 1'h0});
			cmd <= {3'($urandom), 3'h0};
			tick(6);
			chk({mode, rcal, al1}, 32'h1);
		end
		$display("test pins done");
		// Software span mode must silence alarms just like a remote one
		wb(1'h1, CTRL_OFS, 32'h23, rdat);
		tick(2); chk({mode, rcal, status[4:3], al1}, {2'h2, 1'h0, 2'h2, 1'h0});
		wb(1'h0, STATE_OFS, 32'h0, rdat); chk({rdat[12:11], rdat[7:0]}, {2'h2, 8'h10});
		$display("test software mode done");
		wb(1'h1, CTRL_OFS, 32'h7, rdat);
		wb(1'h0, LIMIT1_OFS, 32'h0, rdat); chk(rdat, scale(16'h03e8, PPM_TO_MG_Q16));
		wb(1'h0, LIMIT2_OFS, 32'h0, rdat); chk(rdat, scale(16'h0bb8, PPM_TO_MG_Q16));
		wb(1'h1, CTRL_OFS, 32'h3, rdat);
		wb(1'h0, LIMIT1_OFS, 32'h0, rdat); chk(rdat, {16'h0, LIMIT1_RST});
		wb(1'h0, LIMIT2_OFS, 32'h0, rdat); chk(rdat, {16'h0, LIMIT2_RST});
		wb(1'h0, 8'h20, 32'h0, rdat); chk(rdat, 32'h0);
		$display("test units done");
		complete_run();
	end
endmodule
